// *** logic/pulse_frequency_speed_meter.sv ***
// Pulse frequency meter and speed converter behind an APB register slave
`timescale 1ns/100ps
module pulse_frequency_speed_meter #(
	parameter logic [31:0] WIN_10MS_CYC = 32'(speed_meter_pkg::WIN_10MS_CYC),
	parameter logic [31:0] WIN_100MS_CYC = 32'(speed_meter_pkg::WIN_100MS_CYC),
	parameter logic [31:0] WIN_1S_CYC = 32'(speed_meter_pkg::WIN_1S_CYC),
	parameter logic [31:0] LOW_PERIOD_CYC = 32'(speed_meter_pkg::LOW_PERIOD_CYC)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pulse_in,
	input wire logic [31:0] present_count,
	output logic error_flag
);
	typedef enum logic [2:0] {S_IDLE, S_FREQ, S_FDIV, S_SAT, S_CDIV, S_DONE} state_t;

	state_t state; // Job sequencer state
	logic [15:0] port_sel; // Port selector for read jobs
	logic [15:0] read_code; // Control code for read jobs
	logic [15:0] convert_control_code; // Control code for conversion jobs
	logic [15:0] pulses_per_rev; // Divisor for both conversions
	logic [15:0] dest0; // First destination word
	logic [15:0] dest1; // Following destination word
	logic [8:0] config_bits; // Port enables, quad mode, comparison running
	logic job_conv; // Current job is a conversion
	logic job_rev; // Current job is a revolution count
	logic [31:0] freq; // Measured frequency in Hz
	logic [31:0] result; // Result awaiting the destination words
	logic div_start; // One-cycle divider kick
	logic [31:0] div_a; // Divider dividend
	logic [31:0] div_b; // Divider divisor
	logic [31:0] div_q; // Divider quotient
	logic div_done; // Divider finished this cycle
	logic [31:0] period; // Cycles between the last two edges
	logic [31:0] win_count [3]; // Edges counted in each window

	// APB phases: the access completes one cycle after it starts
	wire logic access = psel & penable;
	wire logic finish = access & pready;
	wire logic wr = finish & pwrite;
	wire logic busy = state != S_IDLE;

	// Address decode
	wire logic hit_port = paddr == speed_meter_pkg::ADDR_PORT;
	wire logic hit_rcode = paddr == speed_meter_pkg::ADDR_READ_CODE;
	wire logic hit_ccode = paddr == speed_meter_pkg::ADDR_CONV_CODE;
	wire logic hit_ppr = paddr == speed_meter_pkg::ADDR_PPR;
	wire logic hit_op = paddr == speed_meter_pkg::ADDR_OP;
	wire logic hit_stat = paddr == speed_meter_pkg::ADDR_STATUS;
	wire logic hit_d0 = paddr == speed_meter_pkg::ADDR_DEST0;
	wire logic hit_d1 = paddr == speed_meter_pkg::ADDR_DEST1;
	wire logic hit_cfg = paddr == speed_meter_pkg::ADDR_CONFIG;
	wire logic mapped = hit_port | hit_rcode | hit_ccode | hit_ppr | hit_op | hit_stat
		| hit_d0 | hit_d1 | hit_cfg;

	// Read data selection; unmapped offsets read zero
	wire logic [31:0] rd_mux = hit_port ? {16'h0000, port_sel}
		: hit_rcode ? {16'h0000, read_code}
		: hit_ccode ? {16'h0000, convert_control_code}
		: hit_ppr ? {16'h0000, pulses_per_rev}
		: hit_stat ? {30'h00000000, error_flag, busy}
		: hit_d0 ? {16'h0000, dest0}
		: hit_d1 ? {16'h0000, dest1}
		: hit_cfg ? {23'h000000, config_bits}
		: 32'h00000000;

	// Job start; a start written while busy is dropped
	wire logic go_read = wr & hit_op & ~busy & (pwdata[1:0] == speed_meter_pkg::OP_READ);
	wire logic go_conv = wr & hit_op & ~busy & (pwdata[1:0] == speed_meter_pkg::OP_CONVERT);
	wire logic op_go = go_read | go_conv;

	// Port classes
	wire logic is_pout = port_sel == speed_meter_pkg::P_POUT0
		|| port_sel == speed_meter_pkg::P_POUT1;
	wire logic is_hsc0 = port_sel == speed_meter_pkg::P_HSC0;
	wire logic is_hsc1 = port_sel == speed_meter_pkg::P_HSC1;
	wire logic is_intr = port_sel >= speed_meter_pkg::P_INTR0
		&& port_sel <= speed_meter_pkg::P_INTR3;
	wire logic is_pwm = port_sel == speed_meter_pkg::P_PWM0
		|| port_sel == speed_meter_pkg::P_PWM1;
	wire logic port_ok = is_pout | is_hsc0 | is_hsc1 | is_intr | is_pwm;

	// Read code classes
	wire logic c_pv = read_code == speed_meter_pkg::C_PV;
	wire logic c_stat = read_code == speed_meter_pkg::C_STATUS;
	wire logic c_range = read_code == speed_meter_pkg::C_RANGE;
	wire logic c_freq = read_code == speed_meter_pkg::C_FREQ_STD
		|| read_code == speed_meter_pkg::C_FREQ_10MS
		|| read_code == speed_meter_pkg::C_FREQ_100MS
		|| read_code == speed_meter_pkg::C_FREQ_1S;
	wire logic code_ok = c_pv | c_stat | c_range | c_freq;

	// Read job error causes
	wire logic bad_range = ~port_ok | ~code_ok;
	wire logic bad_combo = ~((is_pout & (c_pv | c_stat | c_freq))
		| ((is_hsc0 | is_hsc1) & (c_pv | c_stat | c_range | c_freq))
		| (is_intr & c_pv) | (is_pwm & c_stat));
	wire logic range_idle = c_range
		& ((is_hsc0 & ~config_bits[speed_meter_pkg::CFG_RANGE0])
		| (is_hsc1 & ~config_bits[speed_meter_pkg::CFG_RANGE1]));
	wire logic freq_port_bad = c_freq & ~is_hsc0;
	wire logic hsc_off = (is_hsc0 & ~config_bits[speed_meter_pkg::CFG_HSC0])
		| (is_hsc1 & ~config_bits[speed_meter_pkg::CFG_HSC1]);
	wire logic intr_off = is_intr
		& ~config_bits[speed_meter_pkg::CFG_INTR_LSB + int'(port_sel[1:0])];
	wire logic read_err = bad_range | bad_combo | range_idle | freq_port_bad
		| hsc_off | intr_off;

	// Conversion job error causes
	wire logic [3:0] conv_unit = convert_control_code[11:8];
	wire logic [3:0] conv_meth = convert_control_code[7:4];
	wire logic conv_is_rev = convert_control_code == speed_meter_pkg::C_REV_COUNT;
	wire logic conv_is_speed = convert_control_code[15:12] == 4'h0
		&& convert_control_code[3:0] == 4'h0
		&& conv_unit <= speed_meter_pkg::UNIT_MAX
		&& conv_meth <= speed_meter_pkg::METHOD_MAX;
	wire logic conv_err = ~config_bits[speed_meter_pkg::CFG_HSC0]
		| ~(conv_is_rev | conv_is_speed) | (pulses_per_rev == 16'h0000);
	wire logic op_err = go_read ? read_err : conv_err;

	// Method digit shares its place in both codes
	wire logic [1:0] method = job_conv ? conv_meth[1:0] : read_code[5:4];
	wire logic fast = period != 32'h00000000 && period <= LOW_PERIOD_CYC;
	wire logic use_win = method != 2'h0 && fast;
	wire logic [11:0] win_scale = method == 2'h1 ? speed_meter_pkg::SCALE_10MS
		: method == 2'h2 ? speed_meter_pkg::SCALE_100MS : speed_meter_pkg::SCALE_ONE;
	wire logic [31:0] win_sel = method == 2'h1 ? win_count[0]
		: method == 2'h2 ? win_count[1] : win_count[2];
	wire logic [43:0] win_prod = win_sel * win_scale;
	wire logic [31:0] win_freq = win_prod[31:0];

	// Saturation limit follows the counter input method
	wire logic quad = config_bits[speed_meter_pkg::CFG_QUAD];
	wire logic [31:0] freq_lim = quad ? speed_meter_pkg::MAX_FREQ_QUAD
		: speed_meter_pkg::MAX_FREQ;
	wire logic [31:0] sat_freq = freq > freq_lim ? freq_lim : freq;

	// Unit scaling of the quotient; revolution count stays unscaled
	wire logic [11:0] unit_mult = job_rev ? speed_meter_pkg::SCALE_ONE
		: conv_unit == 4'h0 ? speed_meter_pkg::SEC_PER_MIN
		: conv_unit == 4'h1 ? speed_meter_pkg::SCALE_ONE
		: speed_meter_pkg::SEC_PER_HOUR;
	wire logic [43:0] unit_prod = div_q * unit_mult;
	wire logic [31:0] unit_res = unit_prod[43:32] != 12'h000 ? 32'hffffffff
		: unit_prod[31:0];

	// Measurement front end on counter input 0 only
	freq_window #(
		.WIN_CYC('{WIN_10MS_CYC, WIN_100MS_CYC, WIN_1S_CYC}),
		.PERIOD_MAX(WIN_1S_CYC)
	) u_window (
		.pclk(pclk),
		.presetn(presetn),
		.pulse_in(pulse_in),
		.period(period),
		.win_count(win_count)
	);

	// Shared divider: standard frequency, then division by pulses per rev
	div_unit u_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(div_start),
		.dividend(div_a),
		.divisor(div_b),
		.quotient(div_q),
		.done(div_done)
	);

	// APB answer registers: one wait state, data valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			if (access & ~pready) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
				pslverr <= ~mapped;
			end
		end
	end

	// Software-written setup registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_sel <= 16'h0000;
			read_code <= 16'h0000;
			convert_control_code <= 16'h0000;
			pulses_per_rev <= 16'h0000;
			config_bits <= speed_meter_pkg::CONFIG_RESET;
		end else if (wr) begin
			if (hit_port) port_sel <= pwdata[15:0];
			else if (hit_rcode) read_code <= pwdata[15:0];
			else if (hit_ccode) convert_control_code <= pwdata[15:0];
			else if (hit_ppr) pulses_per_rev <= pwdata[15:0];
			else if (hit_cfg) config_bits <= pwdata[8:0];
		end
	end

	// Error flag reflects the most recent started job
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) error_flag <= 1'b0;
		else if (op_go) error_flag <= op_err;
	end

	// Destination words, written only by a job that passed its checks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dest0 <= 16'h0000;
			dest1 <= 16'h0000;
		end else if (state == S_DONE) begin
			dest0 <= result[15:0];
			dest1 <= result[31:16];
		end
	end

	// Job sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			job_conv <= 1'b0;
			job_rev <= 1'b0;
			freq <= 32'h00000000;
			result <= 32'h00000000;
			div_start <= 1'b0;
			div_a <= 32'h00000000;
			div_b <= 32'h00000000;
		end else begin
			div_start <= 1'b0;
			case (state)
				S_IDLE: begin
					// A refused job leaves every result register alone
					if (op_go && !op_err) begin
						job_conv <= go_conv;
						job_rev <= go_conv & conv_is_rev;
						if (go_read && !c_freq) begin
							// Only the counter 0 count is visible to this block
							result <= (is_hsc0 && c_pv) ? present_count : 32'h00000000;
							state <= S_DONE;
						end else if (go_conv && conv_is_rev) begin
							div_a <= present_count;
							div_b <= {16'h0000, pulses_per_rev};
							div_start <= 1'b1;
							state <= S_CDIV;
						end else begin
							state <= S_FREQ;
						end
					end
				end
				S_FREQ: begin
					if (use_win) begin
						freq <= win_freq;
						state <= S_SAT;
					end else if (period == 32'h00000000) begin
						// No edge within a second reads as standstill
						freq <= 32'h00000000;
						state <= S_SAT;
					end else begin
						div_a <= 32'(speed_meter_pkg::CLK_HZ);
						div_b <= period;
						div_start <= 1'b1;
						state <= S_FDIV;
					end
				end
				S_FDIV: begin
					if (div_done) begin
						freq <= div_q;
						state <= S_SAT;
					end
				end
				S_SAT: begin
					if (job_conv) begin
						div_a <= sat_freq;
						div_b <= {16'h0000, pulses_per_rev};
						div_start <= 1'b1;
						state <= S_CDIV;
					end else begin
						result <= sat_freq;
						state <= S_DONE;
					end
				end
				S_CDIV: begin
					if (div_done) begin
						result <= unit_res;
						state <= S_DONE;
					end
				end
				S_DONE: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_job_ok;
		op_go && !op_err;
	endsequence
	sequence s_job_ends;
		##[1:120] state == S_DONE;
	endsequence

	a_refused_dest: assert property (op_go && op_err |=> $stable({dest1, dest0})[*3])
		else $error("destination words changed after a refused job");
	a_bad_port_err: assert property (go_read && bad_range |=> error_flag)
		else $error("out-of-range port or code did not flag an error");
	a_bad_combo_idle: assert property (go_read && bad_combo |=> error_flag && state == S_IDLE)
		else $error("illegal pairing was performed");
	a_range_idle_err: assert property (go_read && range_idle |=> error_flag)
		else $error("range result read with comparison idle not flagged");
	a_freq_port_err: assert property (go_read && c_freq && !is_hsc0 |=> error_flag)
		else $error("frequency read on wrong port not flagged");
	a_hsc_off_err: assert property (go_read && hsc_off |=> error_flag)
		else $error("disabled counter port not flagged");
	a_intr_off_err: assert property (go_read && intr_off |=> error_flag)
		else $error("non-counting interrupt port not flagged");
	a_conv_ppr_err: assert property (go_conv && pulses_per_rev == 16'h0000 |=> error_flag)
		else $error("zero pulses per revolution not flagged");
	a_job_finishes: assert property (s_job_ok |-> s_job_ends)
		else $error("accepted job did not finish in time");
	// Only the frequency path reaches S_DONE from S_SAT; a count read may exceed the limit
	a_sat_limit: assert property (state == S_DONE && $past(state) == S_SAT && !job_conv
		|-> result <= freq_lim)
		else $error("frequency result above its limit");
	a_slow_standard: assert property (state == S_FREQ && !fast |=> state != S_SAT || freq == 0)
		else $error("window count used below the low-frequency limit");
	a_word_split: assert property (state == S_DONE |=> dest0 == $past(result[15:0])
		&& dest1 == $past(result[31:16]))
		else $error("result halves placed in the wrong words");
endmodule

// *** logic/speed_meter_pkg.sv ***
// Shared constants for the pulse frequency and speed meter
package speed_meter_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] ADDR_PORT = 8'h00;
	localparam logic [7:0] ADDR_READ_CODE = 8'h04;
	localparam logic [7:0] ADDR_CONV_CODE = 8'h08;
	localparam logic [7:0] ADDR_PPR = 8'h0c;
	localparam logic [7:0] ADDR_OP = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_DEST0 = 8'h18;
	localparam logic [7:0] ADDR_DEST1 = 8'h1c;
	localparam logic [7:0] ADDR_CONFIG = 8'h20;
	// Operation start codes written to the op register
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_CONVERT = 2'h2;
	// Status and config bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_ERR = 1;
	localparam int CFG_HSC0 = 0;
	localparam int CFG_HSC1 = 1;
	localparam int CFG_INTR_LSB = 2;
	localparam int CFG_QUAD = 6;
	localparam int CFG_RANGE0 = 7;
	localparam int CFG_RANGE1 = 8;
	localparam logic [8:0] CONFIG_RESET = 9'h000;
	// Port selector values
	localparam logic [15:0] P_POUT0 = 16'h0000;
	localparam logic [15:0] P_POUT1 = 16'h0001;
	localparam logic [15:0] P_HSC0 = 16'h0010;
	localparam logic [15:0] P_HSC1 = 16'h0011;
	localparam logic [15:0] P_INTR0 = 16'h0100;
	localparam logic [15:0] P_INTR3 = 16'h0103;
	localparam logic [15:0] P_PWM0 = 16'h1000;
	localparam logic [15:0] P_PWM1 = 16'h1001;
	// Read and conversion control codes
	localparam logic [15:0] C_PV = 16'h0000;
	localparam logic [15:0] C_STATUS = 16'h0001;
	localparam logic [15:0] C_RANGE = 16'h0002;
	localparam logic [15:0] C_FREQ_STD = 16'h0003;
	localparam logic [15:0] C_FREQ_10MS = 16'h0013;
	localparam logic [15:0] C_FREQ_100MS = 16'h0023;
	localparam logic [15:0] C_FREQ_1S = 16'h0033;
	localparam logic [15:0] C_REV_COUNT = 16'h0001;
	localparam logic [3:0] UNIT_MAX = 4'h2;
	localparam logic [3:0] METHOD_MAX = 4'h3;
	// Timing, in the printed units, and derived cycle counts
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int WIN_10MS_MS = 10;
	localparam int WIN_100MS_MS = 100;
	localparam int WIN_1S_MS = 1000;
	localparam int WIN_10MS_CYC = WIN_10MS_MS * (1000000 / CLK_PERIOD_NS);
	localparam int WIN_100MS_CYC = WIN_100MS_MS * (1000000 / CLK_PERIOD_NS);
	localparam int WIN_1S_CYC = WIN_1S_MS * (1000000 / CLK_PERIOD_NS);
	localparam int LOW_FREQ_HZ = 1000;
	localparam int LOW_PERIOD_CYC = CLK_HZ / LOW_FREQ_HZ;
	// Result limits and unit factors
	localparam logic [31:0] MAX_FREQ = 32'h000186a0;
	localparam logic [31:0] MAX_FREQ_QUAD = 32'h00030d40;
	localparam logic [11:0] SEC_PER_MIN = 12'h03c;
	localparam logic [11:0] SEC_PER_HOUR = 12'he10;
	localparam logic [11:0] SCALE_ONE = 12'h001;
	localparam logic [11:0] SCALE_10MS = 12'h064;
	localparam logic [11:0] SCALE_100MS = 12'h00a;
endpackage

// *** logic/freq_window.sv ***
// Pulse period timer and windowed pulse counters for counter input 0
`timescale 1ns/100ps
module freq_window #(
	parameter logic [31:0] WIN_CYC [3] = '{32'h000f4240, 32'h00989680, 32'h05f5e100},
	parameter logic [31:0] PERIOD_MAX = 32'h05f5e100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pulse_in,
	output logic [31:0] period,
	output logic [31:0] win_count [3]
);
	logic pulse_prev; // Last sampled input level
	logic seen; // One edge seen since the last timeout
	logic [31:0] since; // Cycles since the last rising edge
	wire logic rise = pulse_in & ~pulse_prev;
	wire logic stale = since >= PERIOD_MAX;

	// Edge detection on the already synchronous input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pulse_prev <= 1'b0;
		else pulse_prev <= pulse_in;
	end

	// Per-pulse period; zero means no usable period (too slow or no edges)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= 32'h00000001;
			seen <= 1'b0;
			period <= 32'h00000000;
		end else if (rise) begin
			since <= 32'h00000001;
			seen <= 1'b1;
			period <= seen ? since : 32'h00000000;
		end else if (stale) begin
			seen <= 1'b0;
			period <= 32'h00000000;
		end else begin
			since <= since + 32'h00000001;
		end
	end

	// One free-running sampling window per selectable length
	for (genvar i = 0; i < 3; i++) begin : g_win
		logic [31:0] tmr; // Cycles into the current window
		logic [31:0] cnt; // Edges seen in the current window
		wire logic last = tmr == WIN_CYC[i] - 32'h00000001;
		wire logic [31:0] cnt_inc = cnt + {31'h00000000, rise};
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tmr <= 32'h00000000;
				cnt <= 32'h00000000;
				win_count[i] <= 32'h00000000;
			end else if (last) begin
				tmr <= 32'h00000000;
				cnt <= 32'h00000000;
				win_count[i] <= cnt_inc;
			end else begin
				tmr <= tmr + 32'h00000001;
				cnt <= cnt_inc;
			end
		end
	end
endmodule

// *** logic/div_unit.sv ***
// Sequential 32 by 32 bit restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module div_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [31:0] divisor,
	output logic [31:0] quotient,
	output logic done
);
	logic [31:0] rem; // Partial remainder
	logic [31:0] den; // Latched divisor
	logic [5:0] steps; // Bits still to produce
	wire logic [32:0] trial = {rem, quotient[31]};
	wire logic fits = trial >= {1'b0, den};
	wire logic [32:0] diff = trial - {1'b0, den};

	// Dividend shifts out of the quotient register as quotient bits shift in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem <= 32'h00000000;
			den <= 32'h00000000;
			quotient <= 32'h00000000;
			steps <= 6'h00;
			done <= 1'b0;
		end else if (start) begin
			rem <= 32'h00000000;
			den <= divisor;
			quotient <= dividend;
			steps <= 6'h20;
			done <= 1'b0;
		end else if (steps != 6'h00) begin
			rem <= fits ? diff[31:0] : trial[31:0];
			quotient <= {quotient[30:0], fits};
			steps <= steps - 6'h01;
			done <= steps == 6'h01;
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// *** bench/pulse_source.sv ***
// Pulse train source standing in for the encoder on counter input 0
`timescale 1ns/100ps
module pulse_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] period,
	output logic pulse_in,
	output logic [31:0] present_count
);
	logic [31:0] phase; // Cycles into the current period
	// One rising edge per period; period zero stands the line still and low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 32'h0;
			pulse_in <= 1'b0;
			present_count <= 32'h0;
		end else if (period == 32'h0) begin
			pulse_in <= 1'b0;
		end else begin
			phase <= (phase + 32'h1 >= period) ? 32'h0 : phase + 32'h1;
			pulse_in <= (phase < (period >> 1));
			// Count kept in step with the edges so revolution checks can use it
			if (phase == 32'h0)
				present_count <= present_count + 32'h1;
		end
	end
endmodule

// *** bench/pulse_frequency_speed_meter_bench.sv ***
// Self-checking bench for the pulse frequency and speed meter
`timescale 1ns/100ps
module pulse_frequency_speed_meter_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, pulse_in, error_flag;
	logic [7:0] paddr; // APB byte address
	logic [31:0] pwdata, prdata, present_count, period, rd_val, last, x;
	int n_mismatch = 0;
	int n_tests = 0;
	// Short windows keep the run small; scale factors stay 100/10/1
	pulse_frequency_speed_meter #(.WIN_10MS_CYC(32'h64), .WIN_100MS_CYC(32'h3e8),
		.WIN_1S_CYC(32'h2710), .LOW_PERIOD_CYC(32'h32)) u_pulse_frequency_speed_meter (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pulse_in(pulse_in), .present_count(present_count), .error_flag(error_flag));
	pulse_source u_pulse_source (.pclk(pclk), .presetn(presetn), .period(period),
		.pulse_in(pulse_in), .present_count(present_count));
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, then an idle edge so psel is never set twice at one edge
	// Waits for pready however long it takes; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_val = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Start a job, poll busy, check flag and both result words
	task automatic job(input logic [31:0] op, input logic [31:0] exp, input logic e);
		apb(1'b1, speed_meter_pkg::ADDR_OP, op);
		// A job that never ends is caught by the watchdog
		do begin
			apb(1'b0, speed_meter_pkg::ADDR_STATUS, 32'h0);
		end while (rd_val[speed_meter_pkg::ST_BUSY] !== 1'b0);
		chk("status err", {31'h0, e}, {31'h0, rd_val[speed_meter_pkg::ST_ERR]});
		chk("error_flag", {31'h0, e}, {31'h0, error_flag});
		// A refused job must leave the previous result in place
		if (e === 1'b0)
			last = exp;
		apb(1'b0, speed_meter_pkg::ADDR_DEST0, 32'h0);
		chk("dest0", {16'h0, last[15:0]}, rd_val);
		apb(1'b0, speed_meter_pkg::ADDR_DEST1, 32'h0);
		chk("dest1", {16'h0, last[31:16]}, rd_val);
	endtask
	task automatic rd(input logic [15:0] p, input logic [15:0] c, input logic [31:0] r,
		input logic e);
		apb(1'b1, speed_meter_pkg::ADDR_PORT, {16'h0, p});
		apb(1'b1, speed_meter_pkg::ADDR_READ_CODE, {16'h0, c});
		job(32'h1, r, e);
	endtask
	task automatic cv(input logic [15:0] c, input logic [15:0] k, input logic [31:0] r,
		input logic e);
		apb(1'b1, speed_meter_pkg::ADDR_CONV_CODE, {16'h0, c});
		apb(1'b1, speed_meter_pkg::ADDR_PPR, {16'h0, k});
		job(32'h2, r, e);
	endtask
	task automatic test_regs;
		apb(1'b0, speed_meter_pkg::ADDR_CONFIG, 32'h0);
		chk("config reset", 32'h0, rd_val);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, serr});
		chk("unmapped data", 32'h0, rd_val);
		apb(1'b1, speed_meter_pkg::ADDR_DEST0, 32'hffff);
		apb(1'b0, speed_meter_pkg::ADDR_DEST0, 32'h0);
		chk("dest0 read only", 32'h0, rd_val);
		$display("test_regs done");
	endtask
	// Slow input, 50 kHz: every method falls back to per-pulse timing
	task automatic test_std;
		rd(16'h10, 16'h3, 32'hc350, 1'b0);
		rd(16'h10, 16'h33, 32'hc350, 1'b0);
		cv(16'h0000, 16'h7, 32'h689e8, 1'b0);
		cv(16'h0100, 16'h7, 32'h1be6, 1'b0);
		cv(16'h0200, 16'h7, 32'h1885260, 1'b0);
		cv(16'h0030, 16'h7, 32'h689e8, 1'b0);
		$display("test_std done");
	endtask
	// Fast input, five edges per 100 cycles, windows give 500
	task automatic test_win;
		period <= 32'h14;
		// Two full 1 s windows pass with no counter reset before any window read
		repeat (20100) @(posedge pclk);
		rd(16'h10, 16'h13, 32'h1f4, 1'b0);
		rd(16'h10, 16'h23, 32'h1f4, 1'b0);
		rd(16'h10, 16'h33, 32'h1f4, 1'b0);
		rd(16'h10, 16'h3, 32'h186a0, 1'b0);
		cv(16'h0000, 16'h1, 32'h5b8d80, 1'b0);
		cv(16'h0010, 16'h1, 32'h7530, 1'b0);
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h43);
		rd(16'h10, 16'h3, 32'h30d40, 1'b0);
		$display("test_win done");
	endtask
	// Refused requests: flag raised, destination words kept; then three reads accepted: interrupt and range once enabled, PWM status with no enable
	task automatic test_err;
		logic [15:0] ep [6] = '{16'h5, 16'h10, 16'h1000, 16'h10, 16'h11, 16'h0};
		logic [15:0] ec [6] = '{16'h0, 16'h4, 16'h0, 16'h2, 16'h3, 16'h3};
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h3);
		for (int i = 0; i < 6; i++) begin
			rd(ep[i], ec[i], 32'h0, 1'b1);
		end
		rd(16'h100, 16'h0, 32'h0, 1'b1);
		cv(16'h0000, 16'h0, 32'h0, 1'b1);
		cv(16'h0002, 16'h1, 32'h0, 1'b1);
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h6);
		rd(16'h10, 16'h0, 32'h0, 1'b1);
		cv(16'h0000, 16'h1, 32'h0, 1'b1);
		rd(16'h100, 16'h0, 32'h0, 1'b0);
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h83);
		rd(16'h10, 16'h2, 32'h0, 1'b0);
		rd(16'h1000, 16'h1, 32'h0, 1'b0);
		$display("test_err done");
	endtask
	// Input stopped so the present count is steady during the job
	task automatic test_rev;
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h3);
		period <= 32'h0;
		repeat (5) @(posedge pclk);
		x = present_count;
		rd(16'h10, 16'h0, x, 1'b0);
		cv(16'h0001, 16'h3, x / 32'h3, 1'b0);
		$display("test_rev done");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence: reset, let the period settle, then the scenarios
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		period = 32'h7d0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_regs;
		apb(1'b1, speed_meter_pkg::ADDR_CONFIG, 32'h3);
		repeat (10500) @(posedge pclk);
		test_std;
		test_win;
		test_err;
		test_rev;
		end_of_test;
	end
	// Watchdog, well beyond the roughly 35000 cycles the scenarios need
	initial begin
		#600000;
		n_mismatch++;
		end_of_test;
	end
endmodule
